// file: bsisr_pkg.sv
/*
 * Shared constants and types of the bias supply serial register port:
 * slave address, register map, reset values, field masks, bus timing
 * and the host controller's own register layout.
 * Assumes a single 50 MHz system clock on both ends.
 */
package bsisr_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h3E;
    localparam logic [7:0] POS_OFS = 8'h00;
    localparam logic [7:0] NEG_OFS = 8'h01;
    localparam logic [7:0] CTRL_OFS = 8'h03;
    localparam logic [7:0] POS_RST = 8'h0A;
    localparam logic [7:0] NEG_RST = 8'h0A;
    localparam logic [7:0] CTRL_RST = 8'h03;
    localparam logic [7:0] POS_MASK = 8'h1F;
    localparam logic [7:0] NEG_MASK = 8'h1F;
    localparam logic [7:0] CTRL_MASK = 8'h43;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CLK_HZ = 50000000;
    localparam int BUS_HZ = 400000;
    // A quarter bus period rounds up so the bus never exceeds its rate.
    localparam int QTR_CYC = (CLK_HZ + 4 * BUS_HZ - 1) / (4 * BUS_HZ);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
    localparam logic [7:0] HCMD_OFS = 8'h00;
    localparam logic [7:0] HSTAT_OFS = 8'h04;
    localparam int CMD_TX_LSB = 0;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_WRITE_BIT = 10;
    localparam int CMD_READ_BIT = 11;
    localparam int CMD_ACK_BIT = 12;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_RX_LSB = 8;
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_ADDR = 3'h1,
        DS_ACK = 3'h2,
        DS_WRITE = 3'h3,
        DS_READ = 3'h4,
        DS_RACK = 3'h5
    } bsisr_dstate_type;
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_START = 2'h1,
        HS_STOP = 2'h2,
        HS_BYTE = 2'h3
    } bsisr_hstate_type;
endpackage

// file: bsisr_if.sv
/*
 * Two-wire bus carrier joining the host controller and the device.
 * Each open-drain driver pulls its line low only when its enable is
 * low and its output is low; the lines otherwise rest high.
 */
`timescale 1ns/100ps
interface bsisr_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );
    modport host (
        input scl,
        input sda,
        output host_scl_o,
        output host_scl_oe_n,
        output host_sda_o,
        output host_sda_oe_n
    );
endinterface

// file: bsisr_dev.sv
/*
 * Device end: two-wire slave with a register pointer and the three
 * bias level and control registers, all on the system clock.
 * Assumes the bus lines arrive asynchronously and the master does not
 * need clock stretching.
 */
`timescale 1ns/100ps
// Functional notes
// - Slave only, up to fast rate.
// - Data fall with clock high starts.
// - Data rise with clock high stops.
// - Change data low, sample clock high.
// - Bytes MSB first, ninth bit acknowledges.
// - Acknowledger holds data low through pulse.
// - First byte: address plus direction bit.
// - Acknowledge own address both directions.
// - First written byte loads pointer.
// - Acknowledge, store, increment per data byte.
// - Any data byte count accepted.
// - Reads start at the kept pointer.
// - Master nacks last; device releases data.
// - Repeated start expects fresh address.
// - Master starts only on idle bus.
// - Registers at 0x00, 0x01, 0x03.
// - Positive level code, reset 0x0A.
// - Negative level code, reset 0x0A.
// - Software writes zero to reserved bits.
// - Control discharge and headroom, reset 0x03.
module bsisr_dev (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    bsisr_if.dev BUS,
    output logic [7:0] POS_LEVEL,
    output logic [7:0] NEG_LEVEL,
    output logic [7:0] RAIL_CONTROL
);
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_s3_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_s3_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    bsisr_pkg::bsisr_dstate_type state_q;
    bsisr_pkg::bsisr_dstate_type state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic first_q;
    logic first_d;
    logic rd_q;
    logic rd_d;
    logic mack_q;
    logic mack_d;
    logic oe_n_q;
    logic oe_n_d;
    logic sda_out_q;
    logic [7:0] pos_q;
    logic [7:0] pos_d;
    logic [7:0] neg_q;
    logic [7:0] neg_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] rdata;
    logic go_read;

    // The second and third stages feed the edge detectors.
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= BUS.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= BUS.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // At 50 MHz a fast-mode clock phase spans dozens of samples.
    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    always_comb begin
        case (ptr_q)
            bsisr_pkg::POS_OFS: rdata = pos_q & bsisr_pkg::POS_MASK;
            bsisr_pkg::NEG_OFS: rdata = neg_q & bsisr_pkg::NEG_MASK;
            bsisr_pkg::CTRL_OFS: rdata = ctrl_q & bsisr_pkg::CTRL_MASK;
            default: rdata = bsisr_pkg::ZERO_BYTE;
        endcase
    end

    assign go_read = (state_q == bsisr_pkg::DS_ACK && rd_q) ||
                     (state_q == bsisr_pkg::DS_RACK && mack_q);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        first_d = first_q;
        rd_d = rd_q;
        mack_d = mack_q;
        oe_n_d = oe_n_q;
        pos_d = pos_q;
        neg_d = neg_q;
        ctrl_d = ctrl_q;
        if (stop_seen) begin
            state_d = bsisr_pkg::DS_IDLE;
            oe_n_d = 1'b1;
        end else if (start_seen) begin
            state_d = bsisr_pkg::DS_ADDR;
            cnt_d = '0;
            oe_n_d = 1'b1;
        end else if (scl_rise) begin
            case (state_q)
                bsisr_pkg::DS_ADDR, bsisr_pkg::DS_WRITE: begin
                    shift_d = {shift_q[6:0], sda_s2_q};
                    cnt_d = cnt_q + 4'h1;
                end
                bsisr_pkg::DS_RACK: begin
                    mack_d = ~sda_s2_q;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                bsisr_pkg::DS_ADDR: begin
                    if (cnt_q == bsisr_pkg::BYTE_BITS) begin
                        if (shift_q[7:1] == bsisr_pkg::SLAVE_ADDR) begin
                            state_d = bsisr_pkg::DS_ACK;
                            oe_n_d = 1'b0;
                            rd_d = shift_q[0];
                            first_d = 1'b1;
                        end else begin
                            state_d = bsisr_pkg::DS_IDLE;
                        end
                    end
                end
                bsisr_pkg::DS_WRITE: begin
                    if (cnt_q == bsisr_pkg::BYTE_BITS) begin
                        state_d = bsisr_pkg::DS_ACK;
                        oe_n_d = 1'b0;
                        first_d = 1'b0;
                        if (first_q) begin
                            ptr_d = shift_q;
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                            case (ptr_q)
                                bsisr_pkg::POS_OFS: begin
                                    pos_d = shift_q & bsisr_pkg::POS_MASK;
                                end
                                bsisr_pkg::NEG_OFS: begin
                                    neg_d = shift_q & bsisr_pkg::NEG_MASK;
                                end
                                bsisr_pkg::CTRL_OFS: begin
                                    ctrl_d = shift_q & bsisr_pkg::CTRL_MASK;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                bsisr_pkg::DS_ACK, bsisr_pkg::DS_RACK: begin
                    if (go_read) begin
                        // The pointer survives between transfers.
                        shift_d = rdata;
                        oe_n_d = rdata[7];
                        ptr_d = ptr_q + 8'h01;
                        cnt_d = 4'h1;
                        state_d = bsisr_pkg::DS_READ;
                    end else if (state_q == bsisr_pkg::DS_ACK) begin
                        state_d = bsisr_pkg::DS_WRITE;
                        oe_n_d = 1'b1;
                        cnt_d = '0;
                    end else begin
                        state_d = bsisr_pkg::DS_IDLE;
                        oe_n_d = 1'b1;
                    end
                end
                bsisr_pkg::DS_READ: begin
                    if (cnt_q == bsisr_pkg::BYTE_BITS) begin
                        state_d = bsisr_pkg::DS_RACK;
                        oe_n_d = 1'b1;
                    end else begin
                        oe_n_d = shift_q[6];
                        shift_d = {shift_q[6:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= bsisr_pkg::DS_IDLE;
            cnt_q <= '0;
            shift_q <= '0;
            ptr_q <= '0;
            first_q <= 1'b0;
            rd_q <= 1'b0;
            mack_q <= 1'b0;
            oe_n_q <= 1'b1;
            sda_out_q <= 1'b0;
            pos_q <= bsisr_pkg::POS_RST;
            neg_q <= bsisr_pkg::NEG_RST;
            ctrl_q <= bsisr_pkg::CTRL_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            first_q <= first_d;
            rd_q <= rd_d;
            mack_q <= mack_d;
            oe_n_q <= oe_n_d;
            sda_out_q <= 1'b0;
            pos_q <= pos_d;
            neg_q <= neg_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign BUS.dev_sda_o = sda_out_q;
    assign BUS.dev_sda_oe_n = oe_n_q;
    assign POS_LEVEL = pos_q;
    assign NEG_LEVEL = neg_q;
    assign RAIL_CONTROL = ctrl_q;
endmodule

// file: bsisr_host.sv
/*
 * Host end: AHB-Lite slave holding a command and a status register
 * and a byte engine that drives the two-wire bus as its only master.
 * Assumes one master on the bus and no clock stretching by the slave.
 */
`timescale 1ns/100ps
module bsisr_host (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    bsisr_if.host BUS,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    logic sda_s1_q;
    logic sda_s2_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic take;
    logic tick;
    logic busy;
    logic wr_pend_q;
    logic wr_pend_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    bsisr_pkg::bsisr_hstate_type hst_q;
    bsisr_pkg::bsisr_hstate_type hst_d;
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic [1:0] ph_q;
    logic [1:0] ph_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic rdop_q;
    logic rdop_d;
    logic ack_q;
    logic ack_d;
    logic nack_q;
    logic nack_d;
    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= BUS.sda;
            sda_s2_q <= sda_s1_q;
            scl_s1_q <= BUS.scl;
            scl_s2_q <= scl_s1_q;
        end
    end

    assign take = HSEL & HTRANS[1] & HREADY;
    assign busy = (hst_q != bsisr_pkg::HS_IDLE);
    assign tick = (div_q == bsisr_pkg::QTR_LAST);

    always_comb begin
        wr_pend_d = take & HWRITE;
        addr_d = take ? HADDR[7:0] : addr_q;
        rdata_d = rdata_q;
        if (take && !HWRITE) begin
            if (HADDR[7:0] == bsisr_pkg::HSTAT_OFS) begin
                rdata_d = (32'(rx_q) << bsisr_pkg::STAT_RX_LSB) |
                          (32'(nack_q) << bsisr_pkg::STAT_NACK_BIT) |
                          32'(busy);
            end else begin
                rdata_d = '0;
            end
        end
        hst_d = hst_q;
        div_d = busy ? (tick ? '0 : div_q + 8'h01) : '0;
        ph_d = ph_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        rdop_d = rdop_q;
        ack_d = ack_q;
        nack_d = nack_q;
        scl_d = scl_q;
        sda_d = sda_q;
        if (!busy) begin
            // Commands arriving while a sequence runs are dropped.
            if (wr_pend_q && addr_q == bsisr_pkg::HCMD_OFS) begin
                ph_d = '0;
                bit_d = '0;
                // Software forms address, pointer and clean data.
                tx_d = HWDATA[bsisr_pkg::CMD_TX_LSB +: 8];
                ack_d = HWDATA[bsisr_pkg::CMD_ACK_BIT];
                if (HWDATA[bsisr_pkg::CMD_START_BIT]) begin
                    hst_d = bsisr_pkg::HS_START;
                end else if (HWDATA[bsisr_pkg::CMD_STOP_BIT]) begin
                    hst_d = bsisr_pkg::HS_STOP;
                end else if (HWDATA[bsisr_pkg::CMD_WRITE_BIT]) begin
                    hst_d = bsisr_pkg::HS_BYTE;
                    rdop_d = 1'b0;
                end else if (HWDATA[bsisr_pkg::CMD_READ_BIT]) begin
                    hst_d = bsisr_pkg::HS_BYTE;
                    rdop_d = 1'b1;
                end
            end
        end else if (tick) begin
            ph_d = ph_q + 2'h1;
            case (hst_q)
                bsisr_pkg::HS_START: begin
                    case (ph_q)
                        2'h0: sda_d = 1'b1;
                        2'h1: scl_d = 1'b1;
                        2'h2: begin
                            if (sda_s2_q && scl_s2_q) begin
                                sda_d = 1'b0;
                            end else begin
                                ph_d = ph_q;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            hst_d = bsisr_pkg::HS_IDLE;
                        end
                    endcase
                end
                bsisr_pkg::HS_STOP: begin
                    case (ph_q)
                        2'h0: sda_d = 1'b0;
                        2'h1: scl_d = 1'b1;
                        2'h2: sda_d = 1'b1;
                        default: hst_d = bsisr_pkg::HS_IDLE;
                    endcase
                end
                default: begin
                    case (ph_q)
                        2'h0: begin
                            if (bit_q < bsisr_pkg::BYTE_BITS) begin
                                sda_d = rdop_q | tx_q[7];
                            end else begin
                                sda_d = ~(rdop_q & ack_q);
                            end
                        end
                        2'h1: scl_d = 1'b1;
                        2'h2: begin
                            if (bit_q < bsisr_pkg::BYTE_BITS) begin
                                rx_d = {rx_q[6:0], sda_s2_q};
                            end else if (!rdop_q) begin
                                nack_d = sda_s2_q;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            tx_d = {tx_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                            if (bit_q == bsisr_pkg::BYTE_BITS) begin
                                hst_d = bsisr_pkg::HS_IDLE;
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_pend_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
            hst_q <= bsisr_pkg::HS_IDLE;
            div_q <= '0;
            ph_q <= '0;
            bit_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            rdop_q <= 1'b0;
            ack_q <= 1'b0;
            nack_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            hst_q <= hst_d;
            div_q <= div_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            rdop_q <= rdop_d;
            ack_q <= ack_d;
            nack_q <= nack_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // Ready and response are fixed flops: every access is zero wait.
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            BUS.host_scl_o <= 1'b0;
            BUS.host_sda_o <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            BUS.host_scl_o <= 1'b0;
            BUS.host_sda_o <= 1'b0;
        end
    end

    assign HRDATA = rdata_q;
    assign BUS.host_scl_oe_n = scl_q;
    assign BUS.host_sda_oe_n = sda_q;
endmodule

// file: bsisr_sva.sv
/*
 * Checker for the two-wire carrier between the host and device ends.
 * Assumes both lines are sampled on the shared system clock.
 */
`timescale 1ns/100ps
module bsisr_sva (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] per_q;
    logic [7:0] per_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic scl_q;
    logic sda_q;
    logic start;
    logic rise;
    // Cycles since the last clock rise, and clock rises since START.
    always_comb begin
        start = scl && scl_q && sda_q && !sda;
        rise = scl && !scl_q;
        per_d = rise ? 8'h00 : per_q + {7'h00, per_q != 8'hFF};
        bit_d = start ? 4'h0 : bit_q + {3'h0, rise && bit_q != 4'hF};
    end
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            per_q <= 8'h00;
            bit_q <= 4'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            per_q <= per_d;
            bit_q <= bit_d;
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    property p_open_drain;
        !dev_sda_o && !host_sda_o && !host_scl_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain output driven high");
    property p_dev_low;
        $changed(dev_sda_oe_n) |-> !scl && !$past(scl);
    endproperty
    a_dev_low: assert property (p_dev_low)
        else $error("device data changed near a high clock");
    property p_ack_hold;
        $rose(scl) && !dev_sda_oe_n |-> (!dev_sda_oe_n && !sda) [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("device low level not held in high clock");
    property p_quiet_addr;
        !dev_sda_oe_n |-> bit_q >= 4'h8;
    endproperty
    a_quiet_addr: assert property (p_quiet_addr)
        else $error("device drove data inside the address byte");
    property p_start_free;
        start |-> dev_sda_oe_n;
    endproperty
    a_start_free: assert property (p_start_free)
        else $error("device driving at a start condition");
    property p_period;
        rise |-> per_q >= 8'h7C;
    endproperty
    a_period: assert property (p_period)
        else $error("bus clock faster than the fast rate");
    property p_start_idle;
        start |-> $past(scl, 8) && $past(sda, 8);
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("start issued without both lines high");
    property p_stop_idle;
        $rose(sda) && scl && $past(scl) |=> (scl && sda) [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("bus not left idle after a stop");
endmodule

// file: tb_top.sv
/*
 * Self-checking bench: drives the host end over AHB-Lite and judges the
 * traffic by status reads and the device's level outputs.
 * Assumes both ends share one system clock and one reset.
 */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] pos;
    logic [7:0] neg;
    logic [7:0] ctl;
    logic [31:0] stat;
    logic [31:0] junk;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [7:0] fa;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    assign wa = {bsisr_pkg::SLAVE_ADDR, 1'b0};
    assign ra = {bsisr_pkg::SLAVE_ADDR, 1'b1};
    assign fa = {bsisr_pkg::SLAVE_ADDR ^ 7'h01, 1'b1};
    bsisr_if i_bsisr_if();
    bsisr_host i_bsisr_host (.CLOCK(clk), .SYS_RST(rst),
        .BUS(i_bsisr_if.host), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp));
    bsisr_dev i_bsisr_dev (.CLOCK(clk), .SYS_RST(rst),
        .BUS(i_bsisr_if.dev), .POS_LEVEL(pos), .NEG_LEVEL(neg),
        .RAIL_CONTROL(ctl));
    bsisr_sva i_bsisr_sva (.CLOCK(clk), .SYS_RST(rst),
        .host_scl_o(i_bsisr_if.host_scl_o),
        .host_scl_oe_n(i_bsisr_if.host_scl_oe_n),
        .host_sda_o(i_bsisr_if.host_sda_o),
        .host_sda_oe_n(i_bsisr_if.host_sda_oe_n),
        .dev_sda_o(i_bsisr_if.dev_sda_o),
        .dev_sda_oe_n(i_bsisr_if.dev_sda_oe_n),
        .scl(i_bsisr_if.scl), .sda(i_bsisr_if.sda));
    always #10 clk = ~clk;
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // The run needs about thirty thousand cycles; a hang ends here.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors = num_errors + 1;
            $display("wrong value run length expected done seen hang");
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic idle_wait();
        stat = 32'h1;
        while (stat[0] !== 1'b0) begin
            ahb(1'b0, bsisr_pkg::HSTAT_OFS, 32'h0, stat);
        end
    endtask
    // Commands are issued only on an idle engine, as a refused one is lost.
    task automatic cmd(input logic [31:0] c);
        idle_wait();
        ahb(1'b1, bsisr_pkg::HCMD_OFS, c, junk);
        idle_wait();
    endtask
    task automatic wbyte(input logic [7:0] b, input logic nack);
        cmd({24'h4, b});
        chk("ack bit", {31'h0, nack}, {31'h0, stat[1]});
    endtask
    task automatic rbyte(input logic ack, input logic [7:0] exp);
        cmd({19'h0, ack, 12'h800});
        chk("read byte", {24'h0, exp}, {24'h0, stat[15:8]});
    endtask
    task automatic t_write();
        cmd(32'h100);
        wbyte(wa, 1'b0);
        wbyte(bsisr_pkg::POS_OFS, 1'b0);
        wbyte(8'h17, 1'b0);
        wbyte(8'h15, 1'b0);
        wbyte(8'h00, 1'b0);
        wbyte(8'h42, 1'b0);
        cmd(32'h200);
        chk("pos level", 32'h17, {24'h0, pos});
        chk("neg level", 32'h15, {24'h0, neg});
        chk("control", 32'h42, {24'h0, ctl});
    endtask
    task automatic t_rep();
        cmd(32'h100);
        wbyte(wa, 1'b0);
        wbyte(bsisr_pkg::NEG_OFS, 1'b0);
        cmd(32'h100);
        wbyte(ra, 1'b0);
        rbyte(1'b1, 8'h15);
        rbyte(1'b0, 8'h00);
        cmd(32'h200);
        cmd(32'h100);
        wbyte(ra, 1'b0);
        rbyte(1'b0, 8'h42);
        cmd(32'h200);
    endtask
    task automatic t_foreign();
        cmd(32'h100);
        wbyte(fa ^ 8'h01, 1'b1);
        wbyte(bsisr_pkg::POS_OFS, 1'b1);
        wbyte(8'h01, 1'b1);
        cmd(32'h100);
        wbyte(fa, 1'b1);
        rbyte(1'b0, 8'hFF);
        cmd(32'h200);
        chk("pos level", 32'h17, {24'h0, pos});
    endtask
    task automatic t_reset();
        cmd(32'h100);
        ahb(1'b1, bsisr_pkg::HCMD_OFS, {24'h4, wa}, junk);
        repeat (300) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("pos level", 32'h0A, {24'h0, pos});
        chk("neg level", 32'h0A, {24'h0, neg});
        chk("control", 32'h03, {24'h0, ctl});
        ahb(1'b0, 8'h08, 32'h0, stat);
        chk("unmapped", 32'h0, stat);
    endtask
    task automatic t_defaults();
        cmd(32'h100);
        wbyte(ra, 1'b0);
        rbyte(1'b1, 8'h0A);
        rbyte(1'b1, 8'h0A);
        rbyte(1'b1, 8'h00);
        rbyte(1'b0, 8'h03);
        cmd(32'h200);
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_write();
        t_rep();
        t_foreign();
        t_reset();
        t_defaults();
        conclude();
    end
endmodule
